//--- rtl/wavegen_pkg.sv
/*
 * Constants for the complementary waveform generator: mode codes, dead-band
 * width, clock rates and synchroniser depth.
 * Assumes one 20 MHz system clock; the fast oscillator rate is emulated.
 */
package wavegen_pkg;
    localparam int DB_WIDTH = 6;
    localparam int SYNC_STAGES = 3;
    localparam logic [2:0] MODE_STEER_ASYNC = 3'h0;
    localparam logic [2:0] MODE_STEER_SYNC = 3'h1;
    localparam logic [2:0] MODE_FULL_FWD = 3'h2;
    localparam logic [2:0] MODE_FULL_REV = 3'h3;
    localparam logic [2:0] MODE_HALF = 3'h4;
    localparam logic [2:0] MODE_PUSH_PULL = 3'h5;
    localparam int ACC_WIDTH = 26;
    localparam logic [ACC_WIDTH-1:0] SYS_CLK_HZ = 26'h1312D00;
    localparam logic [ACC_WIDTH-1:0] FAST_OSC_HZ = 26'h0F42400;
    localparam logic [3:0] OUT_RESET = 4'h0;
endpackage : wavegen_pkg

//--- rtl/deadband_timer.sv
/*
 * One dead-band timer: counts ticks from zero up to a limit after a start.
 * Assumes start and abort are single-cycle pulses on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
module deadband_timer import wavegen_pkg::*; #(
    parameter int WIDTH = DB_WIDTH
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // control
    input wire logic enable_i,
    input wire logic tick_i,
    input wire logic start_i,
    input wire logic abort_i,
    input wire logic [WIDTH-1:0] limit_i,
    // status
    output logic done_o
);
    logic [WIDTH-1:0] cnt_reg;
    logic run_reg;
    logic done_reg;

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (start_i) begin
            cnt_reg <= '0;
            run_reg <= enable_i;
            done_reg <= !enable_i;
        end else if (abort_i) begin
            run_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (run_reg && tick_i) begin
            if (cnt_reg == limit_i) begin
                run_reg <= 1'b0;
                done_reg <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end

    assign done_o = done_reg;

    count_reach_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (run_reg && tick_i && cnt_reg == limit_i && !start_i && !abort_i) |=> done_o)
        else $error("dead band did not end at its limit");
    count_early_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        ($rose(done_reg) && $past(run_reg) && !$past(start_i)) |-> $past(cnt_reg) == $past(limit_i))
        else $error("dead band ended before its limit");
endmodule : deadband_timer
`default_nettype wire

//--- rtl/complementary_waveform_generator.sv
/*
 * Complementary waveform generator: steers one input waveform onto four
 * outputs in half-bridge, push-pull, full-bridge and steering modes.
 * Assumes control bits come from logic on clk_sys_i; the waveform and the
 * shutdown pin arrive unsynchronised.
 */
`timescale 1ns/100ps
`default_nettype none
module complementary_waveform_generator import wavegen_pkg::*; (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // input waveform
    input wire logic wave_data_i,
    // control
    input wire logic enable_i,
    input wire logic [2:0] mode_i,
    input wire logic clock_source_sel_i,
    input wire logic [3:0] output_polarity_i,
    input wire logic [3:0] steer_select_bits_i,
    input wire logic [3:0] steer_level_i,
    // dead band
    input wire logic [DB_WIDTH-1:0] rise_deadband_count_i,
    input wire logic [DB_WIDTH-1:0] fall_deadband_count_i,
    input wire logic rise_db_en_i,
    input wire logic fall_db_en_i,
    input wire logic db_load_req_i,
    // shutdown
    input wire logic shutdown_src_n_i,
    input wire logic shutdown_sw_i,
    input wire logic auto_restart_en_i,
    input wire logic shutdown_clear_i,
    input wire logic [3:0] override_level_i,
    // outputs
    output logic wave_out_a_o,
    output logic wave_out_b_o,
    output logic wave_out_c_o,
    output logic wave_out_d_o,
    output logic shutdown_active_o,
    output logic db_load_pending_o,
    output logic direction_rev_o
);
    // active-high request to pin level through a polarity bit
    function automatic logic [3:0] polar(input logic [3:0] act, input logic [3:0] pol);
        polar = ~(act ^ pol);
    endfunction : polar

    logic [SYNC_STAGES-1:0] in_sync_reg;
    logic [SYNC_STAGES-1:0] sd_sync_reg;
    logic in_lvl_reg;
    logic in_prev_reg;
    logic sd_lvl_reg;
    logic rise_evt;
    logic fall_evt;
    logic [ACC_WIDTH-1:0] acc_reg;
    logic [ACC_WIDTH-1:0] acc_sum;
    logic tick;
    logic [DB_WIDTH-1:0] rise_db_reg;
    logic [DB_WIDTH-1:0] fall_db_reg;
    logic load_pend_reg;
    logic shutdown_reg;
    logic sd_src;
    logic sd_now;
    logic pp_sel_reg;
    logic dir_reg;
    logic fb_hold_reg;
    logic [3:0] steer_reg;
    logic [3:0] steer_eff;
    logic full_mode;
    logic steer_mode;
    logic rise_start;
    logic rise_abort;
    logic fall_start;
    logic fall_abort;
    logic rise_done;
    logic fall_done;
    logic [3:0] act_next;
    logic [3:0] out_next;
    logic [3:0] out_reg;

    assign full_mode = (mode_i == MODE_FULL_FWD) || (mode_i == MODE_FULL_REV);
    assign steer_mode = (mode_i == MODE_STEER_ASYNC) || (mode_i == MODE_STEER_SYNC);

    // three stages; a change counts once stages two and three agree
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            in_sync_reg <= '0;
            sd_sync_reg <= '1;
        end else begin
            in_sync_reg <= {in_sync_reg[SYNC_STAGES-2:0], wave_data_i};
            sd_sync_reg <= {sd_sync_reg[SYNC_STAGES-2:0], shutdown_src_n_i};
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            in_lvl_reg <= 1'b0;
            in_prev_reg <= 1'b0;
            sd_lvl_reg <= 1'b1;
        end else begin
            if (in_sync_reg[1] == in_sync_reg[2]) begin
                in_lvl_reg <= in_sync_reg[2];
            end
            if (sd_sync_reg[1] == sd_sync_reg[2]) begin
                sd_lvl_reg <= sd_sync_reg[2];
            end
            in_prev_reg <= in_lvl_reg;
        end
    end

    assign rise_evt = in_lvl_reg && !in_prev_reg;
    assign fall_evt = !in_lvl_reg && in_prev_reg;

    // fast oscillator rate emulated by a fractional tick; no second clock domain
    assign acc_sum = acc_reg + FAST_OSC_HZ;
    assign tick = clock_source_sel_i ? (acc_sum >= SYS_CLK_HZ) : 1'b1;

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            acc_reg <= '0;
        end else if (!clock_source_sel_i) begin
            acc_reg <= '0;
        end else if (tick) begin
            acc_reg <= acc_sum - SYS_CLK_HZ;
        end else begin
            acc_reg <= acc_sum;
        end
    end

    // dead-band values: copied while disabled, else on a load at input fall
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rise_db_reg <= '0;
            fall_db_reg <= '0;
        end else if (!enable_i || (load_pend_reg && fall_evt)) begin
            rise_db_reg <= rise_deadband_count_i;
            fall_db_reg <= fall_deadband_count_i;
        end
    end

    // a new load request wins over the fall that consumes the old one
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            load_pend_reg <= 1'b0;
        end else if (db_load_req_i && enable_i) begin
            load_pend_reg <= 1'b1;
        end else if (fall_evt || !enable_i) begin
            load_pend_reg <= 1'b0;
        end
    end

    // shutdown: a live source always wins over any restart or clear
    assign sd_src = !sd_lvl_reg || shutdown_sw_i;
    assign sd_now = sd_src || shutdown_reg;

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shutdown_reg <= 1'b0;
        end else if (sd_src) begin
            shutdown_reg <= 1'b1;
        end else if (auto_restart_en_i ? rise_evt : shutdown_clear_i) begin
            shutdown_reg <= 1'b0;
        end
    end

    // push-pull sequencer; flips after each pulse so A takes the first
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pp_sel_reg <= 1'b0;
        end else if (!enable_i || sd_now) begin
            pp_sel_reg <= 1'b0;
        end else if (mode_i == MODE_PUSH_PULL && fall_evt) begin
            pp_sel_reg <= !pp_sel_reg;
        end
    end

    // direction follows the low mode bit; in enabled full-bridge it switches only at an input rise
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dir_reg <= 1'b0;
            fb_hold_reg <= 1'b0;
        end else if (!full_mode || !enable_i) begin
            dir_reg <= mode_i[0];
            fb_hold_reg <= 1'b0;
        end else if (rise_evt && (mode_i[0] != dir_reg)) begin
            dir_reg <= mode_i[0];
            fb_hold_reg <= 1'b1;
        end else if (fall_evt) begin
            fb_hold_reg <= 1'b0;
        end
    end

    // steering selection; the sync case also looks through on the rise itself
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            steer_reg <= '0;
        end else if (mode_i == MODE_STEER_ASYNC) begin
            steer_reg <= steer_select_bits_i;
        end else if (mode_i == MODE_STEER_SYNC && rise_evt) begin
            steer_reg <= steer_select_bits_i;
        end
    end

    assign steer_eff = (mode_i == MODE_STEER_SYNC && rise_evt) ? steer_select_bits_i : steer_reg;

    // timer starts: edges in half-bridge, direction changes in full-bridge
    always_comb begin
        rise_start = 1'b0;
        fall_start = 1'b0;
        rise_abort = fall_evt;
        fall_abort = fall_evt;
        if (mode_i == MODE_HALF) begin
            rise_start = rise_evt;
            fall_start = fall_evt;
            fall_abort = rise_evt;
        end else if (full_mode) begin
            rise_start = rise_evt && mode_i[0] && !dir_reg;
            fall_start = rise_evt && !mode_i[0] && dir_reg;
        end
    end

    deadband_timer #(
        .WIDTH(DB_WIDTH)
    ) rise_timer (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .enable_i(rise_db_en_i),
        .tick_i(tick),
        .start_i(rise_start),
        .abort_i(rise_abort),
        .limit_i(rise_db_reg),
        .done_o(rise_done)
    );

    deadband_timer #(
        .WIDTH(DB_WIDTH)
    ) fall_timer (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .enable_i(fall_db_en_i),
        .tick_i(tick),
        .start_i(fall_start),
        .abort_i(fall_abort),
        .limit_i(fall_db_reg),
        .done_o(fall_done)
    );

    // active-high drive request per output, bit 0 is A
    always_comb begin
        act_next = 4'h0;
        case (mode_i)
            MODE_HALF: begin
                act_next[0] = in_lvl_reg && rise_done;
                act_next[1] = !in_lvl_reg && fall_done;
                act_next[3:2] = act_next[1:0];
            end
            MODE_PUSH_PULL: begin
                act_next[0] = in_lvl_reg && !pp_sel_reg;
                act_next[1] = in_lvl_reg && pp_sel_reg;
                act_next[3:2] = act_next[1:0];
            end
            MODE_FULL_FWD, MODE_FULL_REV: begin
                if (!dir_reg) begin
                    act_next[0] = 1'b1;
                    act_next[3] = in_lvl_reg && (!fb_hold_reg || fall_done);
                end else begin
                    act_next[2] = 1'b1;
                    act_next[1] = in_lvl_reg && (!fb_hold_reg || rise_done);
                end
            end
            MODE_STEER_ASYNC, MODE_STEER_SYNC: begin
                act_next = {4{in_lvl_reg}} & steer_eff;
            end
            default: begin
                act_next = 4'h0;
            end
        endcase
    end

    // override levels ignore polarity; steering shutdown hits selected pins only
    always_comb begin
        out_next = polar(act_next, output_polarity_i);
        if (!enable_i) begin
            out_next = polar(4'h0, output_polarity_i);
        end else if (steer_mode) begin
            for (int i = 0; i < 4; i++) begin
                if (!steer_eff[i]) begin
                    out_next[i] = steer_level_i[i];
                end else if (sd_now) begin
                    out_next[i] = override_level_i[i];
                end
            end
        end else if (sd_now) begin
            out_next = override_level_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            out_reg <= OUT_RESET;
        end else begin
            out_reg <= out_next;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shutdown_active_o <= 1'b0;
            db_load_pending_o <= 1'b0;
            direction_rev_o <= 1'b0;
        end else begin
            shutdown_active_o <= sd_now;
            db_load_pending_o <= load_pend_reg;
            direction_rev_o <= dir_reg;
        end
    end

    assign wave_out_a_o = out_reg[0];
    assign wave_out_b_o = out_reg[1];
    assign wave_out_c_o = out_reg[2];
    assign wave_out_d_o = out_reg[3];

    disabled_outputs_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        !enable_i |=> out_reg == ~$past(output_polarity_i))
        else $error("outputs not inactive while disabled");
    pp_reset_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (!enable_i || sd_now) |=> !pp_sel_reg)
        else $error("push-pull sequencer not reset");
    pp_alternate_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (enable_i && !sd_now && mode_i == MODE_PUSH_PULL && fall_evt)
        |=> pp_sel_reg != $past(pp_sel_reg))
        else $error("push-pull did not alternate");
    forward_static_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (full_mode && !dir_reg) |-> act_next[2:0] == 3'h1)
        else $error("forward bridge static outputs wrong");
    reverse_static_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (full_mode && dir_reg) |-> (act_next[0] == 1'b0 && act_next[3:2] == 2'h1))
        else $error("reverse bridge static outputs wrong");
    sync_steer_hold_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (mode_i == MODE_STEER_SYNC && !rise_evt) |=> $stable(steer_reg))
        else $error("sync steering changed off an input rise");
    async_steer_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (mode_i == MODE_STEER_ASYNC) |=> steer_reg == $past(steer_select_bits_i))
        else $error("async steering not applied next cycle");
    shutdown_force_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (enable_i && sd_src && !steer_mode) |=> out_reg == $past(override_level_i))
        else $error("shutdown did not force override levels");
    half_deadband_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        (mode_i == MODE_HALF && fall_evt && fall_db_en_i) |-> !act_next[1])
        else $error("inverted output rose without dead band");
endmodule : complementary_waveform_generator
`default_nettype wire

//--- sim/wave_source_model.sv
/*
 * Far-side model: the waveform source feeding the generator and the fault
 * line from the power stage, both unrelated in phase to the system clock.
 * Assumes the bench requests levels at clock edges and holds each for
 * several clocks.
 */
`timescale 1ns/100ps
`default_nettype none
module wave_source_model (
    // bench requests
    input wire logic wave_req_i,
    input wire logic fault_req_i,
    // lines into the generator
    output logic wave_data_o,
    output logic fault_n_o
);
    initial begin
        wave_data_o = 1'b0;
        fault_n_o = 1'b1;
    end

    // edges land anywhere inside a clock, so sync jitter gets exercised
    always @(wave_req_i) wave_data_o <= #(5 + ($urandom % 40)) wave_req_i;
    // fault pin is active low, released when no fault is requested
    always @(fault_req_i) fault_n_o <= #(5 + ($urandom % 40)) ~fault_req_i;
endmodule : wave_source_model
`default_nettype wire

//--- sim/complementary_waveform_generator_test.sv
/*
 * Self-checking bench for the complementary waveform generator.
 * Assumes wavegen_pkg and the source model are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module complementary_waveform_generator_test import wavegen_pkg::*; ;
    logic clk_sys_i;
    logic reset_n_i;
    logic wave_req;
    logic fault_req;
    logic wave_data_i;
    logic shutdown_src_n_i;
    logic enable_i;
    logic [2:0] mode_i;
    logic clock_source_sel_i;
    logic [3:0] output_polarity_i;
    logic [3:0] steer_select_bits_i;
    logic [3:0] steer_level_i;
    logic [DB_WIDTH-1:0] rise_deadband_count_i;
    logic [DB_WIDTH-1:0] fall_deadband_count_i;
    logic rise_db_en_i;
    logic fall_db_en_i;
    logic shutdown_sw_i;
    logic shutdown_clear_i;
    logic [3:0] override_level_i;
    logic wave_out_a_o;
    logic wave_out_b_o;
    logic wave_out_c_o;
    logic wave_out_d_o;
    logic shutdown_active_o;
    logic db_load_pending_o;
    logic direction_rev_o;
    logic load_req;
    logic exp_dir;
    logic exp_load;
    logic [6:0] exp_q[$];
    logic [6:0] got;
    logic [6:0] want;
    logic [31:0] seed_dummy;
    logic w;
    int bad_count;
    int checked;
    event chk_ev;

    wave_source_model src (
        .wave_req_i(wave_req),
        .fault_req_i(fault_req),
        .wave_data_o(wave_data_i),
        .fault_n_o(shutdown_src_n_i)
    );

    // auto restart left idle: only the latched clear path is exercised
    complementary_waveform_generator DUT (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .wave_data_i(wave_data_i),
        .enable_i(enable_i),
        .mode_i(mode_i),
        .clock_source_sel_i(clock_source_sel_i),
        .output_polarity_i(output_polarity_i),
        .steer_select_bits_i(steer_select_bits_i),
        .steer_level_i(steer_level_i),
        .rise_deadband_count_i(rise_deadband_count_i),
        .fall_deadband_count_i(fall_deadband_count_i),
        .rise_db_en_i(rise_db_en_i),
        .fall_db_en_i(fall_db_en_i),
        .db_load_req_i(load_req),
        .shutdown_src_n_i(shutdown_src_n_i),
        .shutdown_sw_i(shutdown_sw_i),
        .auto_restart_en_i(1'b0),
        .shutdown_clear_i(shutdown_clear_i),
        .override_level_i(override_level_i),
        .wave_out_a_o(wave_out_a_o),
        .wave_out_b_o(wave_out_b_o),
        .wave_out_c_o(wave_out_c_o),
        .wave_out_d_o(wave_out_d_o),
        .shutdown_active_o(shutdown_active_o),
        .db_load_pending_o(db_load_pending_o),
        .direction_rev_o(direction_rev_o)
    );

    always #25 clk_sys_i = ~clk_sys_i;

    // active pattern {d,c,b,a} mapped through polarity, shutdown flag low
    function automatic logic [6:0] act(input logic [3:0] v);
        return {exp_load, exp_dir, 1'b0, v ~^ output_polarity_i};
    endfunction : act

    // steered pins follow the wave with polarity, others sit at fixed level
    function automatic logic [6:0] steer(input logic [3:0] s, input logic x);
        return {exp_load, exp_dir, 1'b0, (s & ({4{x}} ~^ output_polarity_i)) | (~s & steer_level_i)};
    endfunction : steer

    // shutdown pattern: override levels as given, polarity ignored
    function automatic logic [6:0] over();
        return {exp_load, exp_dir, 1'b1, override_level_i};
    endfunction : over

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : cyc

    // sampled at the falling edge, well clear of output updates
    task automatic chk(input logic [6:0] e);
        @(negedge clk_sys_i);
        exp_q.push_back(e);
        -> chk_ev;
        @(posedge clk_sys_i);
    endtask : chk

    task automatic wave(input logic x, input int n);
        wave_req <= x;
        cyc(n);
    endtask : wave

    task automatic restart(input logic [2:0] m);
        // mode set while disabled so the direction bit settles before enable
        enable_i <= 1'b0;
        mode_i <= m;
        exp_dir = m[0];
        cyc(2);
        enable_i <= 1'b1;
        cyc(1);
    endtask : restart

    task automatic pulse(input logic on_a);
        wave(1'b1, 8);
        chk(act(on_a ? 4'h5 : 4'hA));
        wave(1'b0, 8);
        chk(act(4'h0));
    endtask : pulse

    task automatic close_out();
        if (bad_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    always @(chk_ev) begin
        got = {db_load_pending_o, direction_rev_o, shutdown_active_o,
               wave_out_d_o, wave_out_c_o, wave_out_b_o, wave_out_a_o};
        want = exp_q.pop_front();
        checked++;
        if (got !== want) begin
            bad_count++;
            $display("BAD t=%0t exp=%h got=%h", $time, want, got);
        end
    end

    // whole run is near 714 clocks; about 28 times that means a hang
    initial begin
        cyc(20000);
        bad_count++;
        close_out();
    end

    initial begin
        seed_dummy = $urandom(32'hB3CD);
        clk_sys_i = 1'b0;
        reset_n_i = 1'b0;
        wave_req = 1'b0;
        fault_req = 1'b0;
        load_req = 1'b0;
        exp_dir = 1'b0;
        exp_load = 1'b0;
        enable_i = 1'b0;
        mode_i = MODE_STEER_ASYNC;
        clock_source_sel_i = 1'b0;
        output_polarity_i = 4'($urandom);
        steer_select_bits_i = 4'h0;
        steer_level_i = 4'($urandom);
        rise_deadband_count_i = 6'h0A;
        fall_deadband_count_i = 6'h0A;
        rise_db_en_i = 1'b1;
        fall_db_en_i = 1'b1;
        shutdown_sw_i = 1'b0;
        shutdown_clear_i = 1'b0;
        override_level_i = 4'($urandom);
        cyc(5);
        reset_n_i <= 1'b1;
        cyc(2);
        chk(act(4'h0));
        restart(MODE_STEER_ASYNC);
        for (int s = 0; s < 16; s++) begin
            w = 1'($urandom);
            wave(w, 8);
            steer_select_bits_i <= 4'(s);
            cyc(3);
            chk(steer(4'(s), w));
        end
        restart(MODE_STEER_SYNC);
        wave(1'b0, 8);
        wave(1'b1, 8);
        chk(steer(4'hF, 1'b1));
        steer_select_bits_i <= 4'h6;
        cyc(6);
        chk(steer(4'hF, 1'b1));
        wave(1'b0, 8);
        chk(steer(4'hF, 1'b0));
        wave(1'b1, 8);
        chk(steer(4'h6, 1'b1));
        restart(MODE_FULL_FWD);
        wave(1'b1, 8);
        chk(act(4'h9));
        wave(1'b0, 8);
        chk(act(4'h1));
        mode_i <= MODE_FULL_REV;
        cyc(8);
        chk(act(4'h1));
        wave(1'b1, 8);
        exp_dir = 1'b1;
        chk(act(4'h4));
        cyc(20);
        chk(act(4'h6));
        wave(1'b0, 8);
        wave(1'b1, 8);
        chk(act(4'h6));
        fault_req <= 1'b1;
        cyc(8);
        chk(over());
        fault_req <= 1'b0;
        cyc(8);
        chk(over());
        shutdown_clear_i <= 1'b1;
        cyc(1);
        shutdown_clear_i <= 1'b0;
        cyc(4);
        chk(act(4'h6));
        rise_deadband_count_i <= 6'h08;
        fall_deadband_count_i <= 6'h08;
        restart(MODE_HALF);
        wave(1'b0, 30);
        wave(1'b1, 8);
        chk(act(4'h0));
        cyc(14);
        chk(act(4'h5));
        wave(1'b0, 8);
        chk(act(4'h0));
        cyc(14);
        chk(act(4'hA));
        fall_db_en_i <= 1'b0;
        wave(1'b1, 30);
        wave(1'b0, 7);
        chk(act(4'hA));
        // new count held back until the next input fall
        rise_deadband_count_i <= 6'h14;
        load_req <= 1'b1;
        cyc(1);
        load_req <= 1'b0;
        exp_load = 1'b1;
        cyc(2);
        chk(act(4'hA));
        wave(1'b1, 8);
        wave(1'b0, 8);
        exp_load = 1'b0;
        chk(act(4'hA));
        wave(1'b1, 20);
        chk(act(4'h0));
        cyc(8);
        chk(act(4'h5));
        // long count so the slower tick rate shows clearly
        fall_db_en_i <= 1'b1;
        rise_deadband_count_i <= 6'h28;
        clock_source_sel_i <= 1'b1;
        restart(MODE_HALF);
        wave(1'b0, 8);
        wave(1'b1, 52);
        chk(act(4'h0));
        cyc(14);
        chk(act(4'h5));
        clock_source_sel_i <= 1'b0;
        wave(1'b0, 8);
        restart(MODE_PUSH_PULL);
        pulse(1'b1);
        pulse(1'b0);
        pulse(1'b1);
        shutdown_sw_i <= 1'b1;
        cyc(3);
        chk(over());
        shutdown_sw_i <= 1'b0;
        cyc(1);
        shutdown_clear_i <= 1'b1;
        cyc(1);
        shutdown_clear_i <= 1'b0;
        cyc(3);
        chk(act(4'h0));
        pulse(1'b1);
        restart(MODE_PUSH_PULL);
        pulse(1'b1);
        cyc(2);
        close_out();
    end
endmodule : complementary_waveform_generator_test
`default_nettype wire
